// ---- src/configurable_io_function_mapper.sv ----
// function mapper for the drive's digital inputs and outputs
// Function
// - each input has its own function setting
// - each output has its own function setting
// - codes 0x43/0x44 drive gear select bits
// - code 0x15 shows stored position command done
// - code 0x16 shows capture completed
// - code 0x17 shows motion control completed
// - codes 0x30-0x3f mirror software output word bits
// - outputs default ready, zero speed, alarm
// - inputs default leaves codes 0x27-0x46 unassigned
// - pulse inhibit in position mode drops pulses
// - forward jog input commands forward jog
//
// Decided for this implementation: the placing of the registers and the APB slave port.
`timescale 1ns/1ns
module configurable_io_function_mapper (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// controller pins
	input wire logic [7:0] digital_input,
	output logic [4:0] digital_output,
	// drive core
	input wire io_map_pkg::drive_status_s drive_status,
	input wire logic position_mode,
	input wire logic ext_pulse_cmd,
	output logic pulse_cmd_accepted,
	output io_map_pkg::di_func_s di_func,
	output logic irq
);
	localparam int NDI = io_map_pkg::NUM_DI;
	localparam int NDO = io_map_pkg::NUM_DO;
	localparam int IRQW = io_map_pkg::IRQ_W;
	localparam int SW = io_map_pkg::SOFT_W;

	logic [7:0] in_func_q [NDI];
	logic [7:0] out_func_q [NDO];
	logic [SW-1:0] software_output_word_q;
	logic [IRQW-1:0] irq_stat_q;
	logic [IRQW-1:0] irq_stat_d;
	logic [IRQW-1:0] irq_mask_q;
	logic [IRQW-1:0] rd_taken_q;
	logic [IRQW-1:0] ev_prev_q;
	logic [IRQW-1:0] ev_now;
	logic [IRQW-1:0] irq_ev;
	logic [NDI-1:0] di_level;
	logic [NDO-1:0] do_d;
	io_map_pkg::di_func_s func_d;
	logic access;
	logic done;
	logic wr;
	logic rdclr;
	logic hit;
	logic [31:0] rd_data;

	level_sync #(
		.W(NDI)
	) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.pin(digital_input),
		.level(di_level)
	);

	// apb handshake: one wait state, answer flopped
	assign access = psel & penable & ~pready;
	assign done = psel & penable & pready;
	assign wr = done & pwrite;
	assign rdclr = done & ~pwrite & (paddr == io_map_pkg::OFS_IRQ_STAT);

	always_comb begin
		rd_data = 32'h0000_0000;
		hit = 1'b0;
		for (int i = 0; i < NDI; i++) begin
			if (paddr == io_map_pkg::OFS_IN_FUNC0
					+ 8'(i) * io_map_pkg::OFS_STEP) begin
				rd_data[7:0] = in_func_q[i];
				hit = 1'b1;
			end
		end
		for (int i = 0; i < NDO; i++) begin
			if (paddr == io_map_pkg::OFS_OUT_FUNC0
					+ 8'(i) * io_map_pkg::OFS_STEP) begin
				rd_data[7:0] = out_func_q[i];
				hit = 1'b1;
			end
		end
		if (paddr == io_map_pkg::OFS_SOFT_OUT) begin
			rd_data[SW-1:0] = software_output_word_q;
			hit = 1'b1;
		end
		if (paddr == io_map_pkg::OFS_DI_LEVEL) begin
			rd_data[NDI-1:0] = di_level;
			hit = 1'b1;
		end
		if (paddr == io_map_pkg::OFS_IRQ_STAT) begin
			rd_data[IRQW-1:0] = irq_stat_q;
			hit = 1'b1;
		end
		if (paddr == io_map_pkg::OFS_IRQ_MASK) begin
			rd_data[IRQW-1:0] = irq_mask_q;
			hit = 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= access;
			pslverr <= access & ~hit;
			if (access) begin
				prdata <= pwrite ? 32'h0000_0000 : rd_data;
			end
		end
	end

	// settings registers; each write touches only its own entry
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < NDI; i++) begin
				in_func_q[i] <= io_map_pkg::DI_RESET[i];
			end
			for (int i = 0; i < NDO; i++) begin
				out_func_q[i] <= io_map_pkg::DO_RESET[i];
			end
		end else if (wr) begin
			for (int i = 0; i < NDI; i++) begin
				if (paddr == io_map_pkg::OFS_IN_FUNC0
						+ 8'(i) * io_map_pkg::OFS_STEP) begin
					in_func_q[i] <= pwdata[7:0];
				end
			end
			for (int i = 0; i < NDO; i++) begin
				if (paddr == io_map_pkg::OFS_OUT_FUNC0
						+ 8'(i) * io_map_pkg::OFS_STEP) begin
					out_func_q[i] <= pwdata[7:0];
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			software_output_word_q <= io_map_pkg::SOFT_OUT_RESET;
			irq_mask_q <= io_map_pkg::IRQ_MASK_RESET;
		end else if (wr) begin
			if (paddr == io_map_pkg::OFS_SOFT_OUT) begin
				software_output_word_q <= pwdata[SW-1:0];
			end
			if (paddr == io_map_pkg::OFS_IRQ_MASK) begin
				irq_mask_q <= pwdata[IRQW-1:0];
			end
		end
	end

	// input decode: several inputs may share a code, levels are or-ed
	always_comb begin
		func_d = '0;
		for (int i = 0; i < NDI; i++) begin
			if (di_level[i]) begin
				case (in_func_q[i])
				io_map_pkg::DI_SERVO_ON: func_d.servo_on_req = 1'b1;
				io_map_pkg::DI_ALARM_RESET: func_d.alarm_reset_req = 1'b1;
				io_map_pkg::DI_MOVE_HOME: func_d.move_home_request = 1'b1;
				io_map_pkg::DI_JOG_FWD: func_d.jog_forward_input = 1'b1;
				io_map_pkg::DI_JOG_REV: func_d.jog_reverse_input = 1'b1;
				io_map_pkg::DI_GEAR_SEL0: begin
					func_d.gear_numerator_select_bit0 = 1'b1;
				end
				io_map_pkg::DI_GEAR_SEL1: begin
					func_d.gear_numerator_select_bit1 = 1'b1;
				end
				io_map_pkg::DI_PULSE_INHIBIT: begin
					func_d.pulse_command_inhibit = 1'b1;
				end
				io_map_pkg::DI_MOTOR_STOP: func_d.motor_stop = 1'b1;
				default: ;
				endcase
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			di_func <= '0;
			pulse_cmd_accepted <= 1'b0;
		end else begin
			di_func <= func_d;
			// decoded value used directly so the inhibit costs no extra cycle
			pulse_cmd_accepted <= ext_pulse_cmd
				& ~(position_mode & func_d.pulse_command_inhibit);
		end
	end

	// output select
	function automatic logic out_level(
		input logic [7:0] code,
		input io_map_pkg::drive_status_s st,
		input logic [SW-1:0] sw
	);
		logic v;
		v = 1'b0;
		if (code[7:4] == io_map_pkg::DO_SOFT_GROUP) begin
			v = sw[code[3:0]];
		end else begin
			case (code)
			io_map_pkg::DO_SERVO_READY: v = st.servo_ready_flag;
			io_map_pkg::DO_SERVO_ON: v = st.servo_on;
			io_map_pkg::DO_ZERO_SPEED: v = st.zero_speed_flag;
			io_map_pkg::DO_SPEED_REACHED: v = st.speed_reached;
			io_map_pkg::DO_POS_DONE: v = st.pos_done;
			io_map_pkg::DO_TORQUE_LIMIT: v = st.torque_limit;
			io_map_pkg::DO_ALARM: v = st.alarm_flag;
			io_map_pkg::DO_BRAKE: v = st.brake;
			io_map_pkg::DO_HOME_DONE: v = st.home_done;
			io_map_pkg::DO_OVERLOAD: v = st.overload_warn;
			io_map_pkg::DO_WARNING: v = st.warning;
			io_map_pkg::DO_POS_OVERFLOW: v = st.pos_overflow;
			io_map_pkg::DO_REV_SOFT_LIMIT: v = st.rev_soft_limit;
			io_map_pkg::DO_FWD_SOFT_LIMIT: v = st.fwd_soft_limit;
			io_map_pkg::DO_CMD_DONE: v = st.pos_cmd_done;
			io_map_pkg::DO_CAPTURE_DONE: v = st.capture_done;
			io_map_pkg::DO_MC_DONE: v = st.motion_control_done;
			io_map_pkg::DO_SPEED_OK: v = st.speed_ok;
			default: v = 1'b0;
			endcase
		end
		return v;
	endfunction

	genvar g;
	generate
		for (g = 0; g < NDO; g++) begin : g_out
			assign do_d[g] = out_level(out_func_q[g], drive_status,
				software_output_word_q);
		end
	endgenerate

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			digital_output <= '0;
		end else begin
			digital_output <= do_d;
		end
	end

	// completion and alarm events, rising edges only
	assign ev_now[io_map_pkg::IRQ_CMD_DONE] = drive_status.pos_cmd_done;
	assign ev_now[io_map_pkg::IRQ_CAPTURE] = drive_status.capture_done;
	assign ev_now[io_map_pkg::IRQ_MC_DONE] =
		drive_status.motion_control_done;
	assign ev_now[io_map_pkg::IRQ_ALARM] = drive_status.alarm_flag;
	assign irq_ev = ev_now & ~ev_prev_q;
	// clear only what the read returned, so a later event is never lost
	assign irq_stat_d = (irq_stat_q & ~(rdclr ? rd_taken_q : '0)) | irq_ev;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ev_prev_q <= '0;
			irq_stat_q <= '0;
			rd_taken_q <= '0;
			irq <= 1'b0;
		end else begin
			ev_prev_q <= ev_now;
			irq_stat_q <= irq_stat_d;
			if (access) begin
				rd_taken_q <= (!pwrite
					&& paddr == io_map_pkg::OFS_IRQ_STAT) ? irq_stat_q : '0;
			end
			irq <= |(irq_stat_d & irq_mask_q);
		end
	end

	// checking helpers
	logic rst_seen_q;
	logic sw_sel0;
	logic known3;
	logic wr_out0;
	logic [7:0] pwdata_lo;
	assign sw_sel0 = software_output_word_q[out_func_q[0][3:0]];
	assign known3 = (out_func_q[3][7:4] == io_map_pkg::DO_SOFT_GROUP)
		|| (out_func_q[3] inside {[8'h01:8'h09], [8'h10:8'h17], 8'h19});
	assign wr_out0 = wr && paddr == io_map_pkg::OFS_OUT_FUNC0;
	assign pwdata_lo = pwdata[7:0];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rst_seen_q <= 1'b0;
		end else begin
			rst_seen_q <= 1'b1;
		end
	end

	a_gear_bit0: assert property (@(posedge pclk) disable iff (!presetn)
		(di_level[3] && in_func_q[3] == io_map_pkg::DI_GEAR_SEL0)
		|=> di_func.gear_numerator_select_bit0)
		else $error("gear select bit 0 not driven");
	a_gear_bit1: assert property (@(posedge pclk) disable iff (!presetn)
		(di_level[4] && in_func_q[4] == io_map_pkg::DI_GEAR_SEL1)
		|=> di_func.gear_numerator_select_bit1)
		else $error("gear select bit 1 not driven");
	a_cmd_done_out: assert property (@(posedge pclk) disable iff (!presetn)
		(out_func_q[0] == io_map_pkg::DO_CMD_DONE)
		|=> digital_output[0] == $past(drive_status.pos_cmd_done))
		else $error("output 1 does not follow command done");
	a_capture_out: assert property (@(posedge pclk) disable iff (!presetn)
		(out_func_q[1] == io_map_pkg::DO_CAPTURE_DONE)
		|=> digital_output[1] == $past(drive_status.capture_done))
		else $error("output 2 does not follow capture done");
	a_mc_done_out: assert property (@(posedge pclk) disable iff (!presetn)
		(out_func_q[2] == io_map_pkg::DO_MC_DONE
		&& $rose(drive_status.motion_control_done))
		|=> $rose(digital_output[2]))
		else $error("output 3 missed motion control done");
	a_soft_mirror: assert property (@(posedge pclk) disable iff (!presetn)
		(out_func_q[0][7:4] == io_map_pkg::DO_SOFT_GROUP)
		|=> digital_output[0] == $past(sw_sel0))
		else $error("output 1 does not mirror software word bit");
	a_default_map: assert property (@(posedge pclk) disable iff (!presetn)
		!rst_seen_q |-> out_func_q[0] == io_map_pkg::DO_SERVO_READY
		&& out_func_q[1] == io_map_pkg::DO_ZERO_SPEED
		&& out_func_q[4] == io_map_pkg::DO_ALARM)
		else $error("output defaults wrong after reset");
	a_default_in: assert property (@(posedge pclk) disable iff (!presetn)
		!rst_seen_q |-> !(in_func_q[0] inside {[8'h27:8'h46]})
		&& !(in_func_q[7] inside {[8'h27:8'h46]}))
		else $error("input default uses an unassigned code");
	a_pulse_inhibit: assert property (@(posedge pclk) disable iff (!presetn)
		(position_mode && func_d.pulse_command_inhibit)
		|=> !pulse_cmd_accepted)
		else $error("pulse passed while inhibited");
	a_jog_forward: assert property (@(posedge pclk) disable iff (!presetn)
		(di_level[1] && in_func_q[1] == io_map_pkg::DI_JOG_FWD)
		|=> di_func.jog_forward_input)
		else $error("forward jog not commanded");
	a_unknown_code: assert property (@(posedge pclk) disable iff (!presetn)
		!known3 |=> !digital_output[3])
		else $error("undefined output code drove output 4");
	a_setting_next: assert property (@(posedge pclk) disable iff (!presetn)
		wr_out0 |=> out_func_q[0] == $past(pwdata_lo)
		&& out_func_q[1] == $past(out_func_q[1]))
		else $error("output 1 setting not taken next cycle");
endmodule

// ---- src/io_map_pkg.sv ----
// shared constants and carriers for the i/o function mapper
package io_map_pkg;
	localparam int NUM_DI = 8;
	localparam int NUM_DO = 5;
	localparam int CODE_W = 8;
	localparam int SOFT_W = 16;
	localparam int IRQ_W = 4;

	// register byte offsets, one aligned word each
	localparam logic [7:0] OFS_IN_FUNC0 = 8'h00;
	localparam logic [7:0] OFS_OUT_FUNC0 = 8'h20;
	localparam logic [7:0] OFS_SOFT_OUT = 8'h34;
	localparam logic [7:0] OFS_DI_LEVEL = 8'h38;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h3c;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h40;
	localparam logic [7:0] OFS_STEP = 8'h04;

	// input function codes
	localparam logic [7:0] DI_SERVO_ON = 8'h01;
	localparam logic [7:0] DI_ALARM_RESET = 8'h02;
	localparam logic [7:0] DI_MOVE_HOME = 8'h27;
	localparam logic [7:0] DI_JOG_FWD = 8'h37;
	localparam logic [7:0] DI_JOG_REV = 8'h38;
	localparam logic [7:0] DI_GEAR_SEL0 = 8'h43;
	localparam logic [7:0] DI_GEAR_SEL1 = 8'h44;
	localparam logic [7:0] DI_PULSE_INHIBIT = 8'h45;
	localparam logic [7:0] DI_MOTOR_STOP = 8'h46;

	// output function codes
	localparam logic [7:0] DO_SERVO_READY = 8'h01;
	localparam logic [7:0] DO_SERVO_ON = 8'h02;
	localparam logic [7:0] DO_ZERO_SPEED = 8'h03;
	localparam logic [7:0] DO_SPEED_REACHED = 8'h04;
	localparam logic [7:0] DO_POS_DONE = 8'h05;
	localparam logic [7:0] DO_TORQUE_LIMIT = 8'h06;
	localparam logic [7:0] DO_ALARM = 8'h07;
	localparam logic [7:0] DO_BRAKE = 8'h08;
	localparam logic [7:0] DO_HOME_DONE = 8'h09;
	localparam logic [7:0] DO_OVERLOAD = 8'h10;
	localparam logic [7:0] DO_WARNING = 8'h11;
	localparam logic [7:0] DO_POS_OVERFLOW = 8'h12;
	localparam logic [7:0] DO_REV_SOFT_LIMIT = 8'h13;
	localparam logic [7:0] DO_FWD_SOFT_LIMIT = 8'h14;
	localparam logic [7:0] DO_CMD_DONE = 8'h15;
	localparam logic [7:0] DO_CAPTURE_DONE = 8'h16;
	localparam logic [7:0] DO_MC_DONE = 8'h17;
	localparam logic [7:0] DO_SPEED_OK = 8'h19;
	localparam logic [3:0] DO_SOFT_GROUP = 4'h3;

	// reset values
	localparam logic [7:0] DI_RESET [NUM_DI] = '{8'h01, 8'h04, 8'h16,
		8'h17, 8'h02, 8'h22, 8'h23, 8'h21};
	localparam logic [7:0] DO_RESET [NUM_DO] = '{DO_SERVO_READY,
		DO_ZERO_SPEED, DO_HOME_DONE, DO_POS_DONE, DO_ALARM};
	localparam logic [15:0] SOFT_OUT_RESET = 16'h0000;
	localparam logic [3:0] IRQ_MASK_RESET = 4'h0;

	// interrupt status bits
	localparam int IRQ_CMD_DONE = 0;
	localparam int IRQ_CAPTURE = 1;
	localparam int IRQ_MC_DONE = 2;
	localparam int IRQ_ALARM = 3;

	typedef struct packed {
		logic servo_ready_flag;
		logic servo_on;
		logic zero_speed_flag;
		logic speed_reached;
		logic pos_done;
		logic torque_limit;
		logic alarm_flag;
		logic brake;
		logic home_done;
		logic overload_warn;
		logic warning;
		logic pos_overflow;
		logic rev_soft_limit;
		logic fwd_soft_limit;
		logic pos_cmd_done;
		logic capture_done;
		logic motion_control_done;
		logic speed_ok;
	} drive_status_s;

	typedef struct packed {
		logic servo_on_req;
		logic alarm_reset_req;
		logic move_home_request;
		logic jog_forward_input;
		logic jog_reverse_input;
		logic gear_numerator_select_bit1;
		logic gear_numerator_select_bit0;
		logic pulse_command_inhibit;
		logic motor_stop;
	} di_func_s;
endpackage

// ---- src/level_sync.sv ----
// two-stage synchroniser for the controller's input pins
`timescale 1ns/1ns
module level_sync #(
	parameter int W = 8
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// pins and synchronised levels
	input wire logic [W-1:0] pin,
	output logic [W-1:0] level
);
	logic [W-1:0] meta_q;

	// first stage feeds only the second
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_q <= '0;
			level <= '0;
		end else begin
			meta_q <= pin;
			level <= meta_q;
		end
	end
endmodule

// ---- verification/io_controller_model.sv ----
// controller-side model of the discrete input pins
`timescale 1ns/1ns
module io_controller_model (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// levels the bench asks for
	input wire logic [7:0] pin_req,
	// drive-facing pins
	output logic [7:0] digital_input
);
	// pins change just after an edge, as a controller's outputs would
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			digital_input <= 8'h00;
		end else begin
			digital_input <= pin_req;
		end
	end
endmodule

// ---- verification/configurable_io_function_mapper_tb_top.sv ----
// bench for the i/o function mapper
`timescale 1ns/1ns
module configurable_io_function_mapper_tb_top;
	logic pclk, presetn, psel, penable, pwrite, position_mode, ext_pulse_cmd;
	logic pready, pslverr, irq, pulse_cmd_accepted, err;
	logic [7:0] paddr, pin_req, digital_input;
	logic [31:0] pwdata, prdata, rd;
	logic [4:0] digital_output;
	io_map_pkg::drive_status_s drive_status;
	io_map_pkg::di_func_s di_func;
	int mismatches = 0;
	int checked = 0;
	logic [7:0] dcode [10] = '{8'h27, 8'h37, 8'h38, 8'h43, 8'h44, 8'h45,
		8'h46, 8'h01, 8'h02, 8'h05};
	logic [8:0] dexp [10] = '{9'h040, 9'h020, 9'h010, 9'h004, 9'h008,
		9'h002, 9'h001, 9'h100, 9'h080, 9'h000};
	logic [7:0] bad [4] = '{8'h18, 8'h1a, 8'h2f, 8'h40};
	localparam logic [7:0] OUT1 = io_map_pkg::OFS_OUT_FUNC0;

	configurable_io_function_mapper configurable_io_function_mapper_i (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .digital_input(digital_input),
		.digital_output(digital_output), .drive_status(drive_status),
		.position_mode(position_mode), .ext_pulse_cmd(ext_pulse_cmd),
		.pulse_cmd_accepted(pulse_cmd_accepted), .di_func(di_func),
		.irq(irq));
	io_controller_model io_controller_model_i (.pclk(pclk),
		.presetn(presetn), .pin_req(pin_req), .digital_input(digital_input));

	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end

	task automatic finish_test();
		$display("checks %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
		checked++;
		if (g !== e) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic cyc(int n);
		repeat (n) @(posedge pclk);
	endtask

	// the slave's wait states are not assumed: pready ends the access, or a limit of 20 cycles
	task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		chk("pready", 1, pready);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(logic [7:0] a, logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rchk(string nm, logic [7:0] a, logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(nm, e, rd);
	endtask

	initial begin
		presetn = 1'b0;
		{psel, penable, pwrite, position_mode, ext_pulse_cmd} = '0;
		paddr = '0;
		pwdata = '0;
		pin_req = '0;
		drive_status = '0;
		cyc(20);
		presetn <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			apb(1'b0, io_map_pkg::OFS_IN_FUNC0 + 8'(4 * i), 32'h0);
			chk("input default", 0, 32'(rd >= 32'h27 && rd <= 32'h46));
		end
		rchk("output1 default", OUT1, 32'h01);
		rchk("output2 default", OUT1 + 8'h04, 32'h03);
		rchk("output5 default", OUT1 + 8'h10, 32'h07);
		rchk("mask reset", io_map_pkg::OFS_IRQ_MASK, 32'h0);
		drive_status <= '{servo_ready_flag: 1'b1, zero_speed_flag: 1'b1,
			alarm_flag: 1'b1, default: 1'b0};
		cyc(3);
		chk("default outputs", 32'h13, 32'(digital_output));
		drive_status <= '1;
		for (int n = 0; n < 16; n++) begin
			wr(OUT1, 32'h30 + 32'(n));
			wr(io_map_pkg::OFS_SOFT_OUT, 32'h1 << n);
			cyc(3);
			chk("mirror set", 1, 32'(digital_output[0]));
			chk("others kept", 32'hf, 32'(digital_output[4:1]));
			wr(io_map_pkg::OFS_SOFT_OUT, ~(32'h1 << n) & 32'hffff);
			cyc(3);
			chk("mirror clear", 0, 32'(digital_output[0]));
		end
		// unknown codes must stay low even with every status bit set
		foreach (bad[i]) begin
			wr(OUT1 + 8'h0c, 32'(bad[i]));
			cyc(3);
			chk("undefined output", 0, 32'(digital_output[3]));
		end
		wr(OUT1, 32'h15);
		wr(OUT1 + 8'h04, 32'h16);
		wr(OUT1 + 8'h08, 32'h17);
		drive_status <= '0;
		cyc(3);
		rchk("clear stale status", io_map_pkg::OFS_IRQ_STAT, 32'h0f);
		chk("events idle", 0, 32'(digital_output[2:0]));
		drive_status <= '{pos_cmd_done: 1'b1, default: 1'b0};
		cyc(3);
		chk("cmd done out", 32'h1, 32'(digital_output[2:0]));
		drive_status <= '{pos_cmd_done: 1'b1, capture_done: 1'b1,
			default: 1'b0};
		cyc(3);
		chk("capture out", 32'h3, 32'(digital_output[2:0]));
		drive_status <= '{pos_cmd_done: 1'b1, capture_done: 1'b1,
			motion_control_done: 1'b1, default: 1'b0};
		cyc(3);
		chk("motion done out", 32'h7, 32'(digital_output[2:0]));
		chk("masked irq", 0, 32'(irq));
		rchk("irq status", io_map_pkg::OFS_IRQ_STAT, 32'h7);
		rchk("status cleared", io_map_pkg::OFS_IRQ_STAT, 32'h0);
		wr(io_map_pkg::OFS_IRQ_MASK, 32'h2);
		drive_status <= '0;
		cyc(3);
		drive_status <= '{capture_done: 1'b1, pos_cmd_done: 1'b1,
			default: 1'b0};
		cyc(3);
		chk("irq raised", 1, 32'(irq));
		rchk("irq status two", io_map_pkg::OFS_IRQ_STAT, 32'h3);
		cyc(3);
		chk("irq cleared", 0, 32'(irq));
		for (int k = 0; k < 10; k++) begin
			wr(io_map_pkg::OFS_IN_FUNC0 + 8'(4 * (k % 8)), 32'(dcode[k]));
			pin_req <= 8'h1 << (k % 8);
			cyc(6);
			chk("input function", 32'(dexp[k]), 32'(di_func));
			pin_req <= 8'h00;
		end
		wr(io_map_pkg::OFS_IN_FUNC0 + 8'h08, 32'h45);
		pin_req <= 8'h04;
		position_mode <= 1'b1;
		ext_pulse_cmd <= 1'b1;
		cyc(6);
		chk("pulse inhibited", 0, 32'(pulse_cmd_accepted));
		position_mode <= 1'b0;
		cyc(3);
		chk("pulse outside mode", 1, 32'(pulse_cmd_accepted));
		pin_req <= 8'h81;
		position_mode <= 1'b1;
		cyc(6);
		chk("pulse not inhibited", 1, 32'(pulse_cmd_accepted));
		wr(io_map_pkg::OFS_DI_LEVEL, 32'h0);
		rchk("input levels", io_map_pkg::OFS_DI_LEVEL, 32'h81);
		chk("mapped error", 0, 32'(err));
		rchk("unmapped read", 8'h44, 32'h0);
		chk("unmapped error", 1, 32'(err));
		finish_test();
	end

	initial begin
		cyc(6000);
		mismatches++;
		$display("[ERR] run expected done seen timeout");
		finish_test();
	end
endmodule
